/* hw/signal_modulator.sv */
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "signal_modulator_map.svh"
module signal_modulator
   import signal_modulator_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        ext_mod_input_pin,
   input  wire logic        pwm_src,
   input  wire logic        comparator_src,
   input  wire logic        sync_sdo_src,
   input  wire logic        serial_tx_src,
   input  wire logic        carrier_high,
   input  wire logic        carrier_low,
   output logic             mod_pin_out,
   output logic             mod_pin_oe,
   output logic             pin_slew_limit,
   output logic             pwm_pin_disconnect,
   output logic             comparator_pin_disconnect,
   output logic             sync_sdo_pin_disconnect,
   output logic             serial_tx_pin_disconnect
);
   logic [7:0]  ctrl_reg;
   logic [7:0]  ctrl_next;
   logic [7:0]  src_reg;
   logic [7:0]  src_next;
   logic        status_reg;
   logic        status_next;
   logic        pin_reg;
   logic        pin_next;
   logic        oe_reg;
   logic        oe_next;
   logic        slew_reg;
   logic        slew_next;
   logic [3:0]  disc_reg;
   logic [3:0]  disc_next;

   logic        aw_held_reg;
   logic        aw_held_next;
   logic [3:0]  awaddr_reg;
   logic [3:0]  awaddr_next;
   logic        w_held_reg;
   logic        w_held_next;
   logic [7:0]  wdata_reg;
   logic [7:0]  wdata_next;
   logic        wstrb_reg;
   logic        wstrb_next;
   logic        bvalid_reg;
   logic        bvalid_next;
   logic [1:0]  bresp_reg;
   logic [1:0]  bresp_next;
   logic        rvalid_reg;
   logic        rvalid_next;
   logic [1:0]  rresp_reg;
   logic [1:0]  rresp_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        awready_reg;
   logic        awready_next;
   logic        wready_reg;
   logic        wready_next;
   logic        arready_reg;
   logic        arready_next;

   logic        mixed;
   logic        aw_fire;
   logic        w_fire;
   logic        wr_go;
   logic [3:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        wr_lane;
   src_sel_t    sel;
   genvar       ch;

   // peripherals that own a pin, in the order of the disconnect outputs
   localparam src_sel_t disc_code [4] = '{`SEL_PWM, `SEL_COMPARATOR,
                                          `SEL_SYNC_SDO, `SEL_SERIAL_TX};

   assign sel = src_reg[`SRC_SEL_MSB:0];

   mod_mixer u_mixer (
      .module_on         (ctrl_reg[`CTRL_ON_BIT]),
      .soft_mod_value    (ctrl_reg[`CTRL_SOFT_BIT]),
      .mod_src_select    (sel),
      .ext_mod_input_pin (ext_mod_input_pin),
      .pwm_src           (pwm_src),
      .comparator_src    (comparator_src),
      .sync_sdo_src      (sync_sdo_src),
      .serial_tx_src     (serial_tx_src),
      .carrier_high      (carrier_high),
      .carrier_low       (carrier_low),
      .mixed             (mixed)
   );

   // write channel: address and data taken in either order or together, one write at a time
   assign aw_fire = s_axi_awvalid & s_axi_awready;
   assign w_fire  = s_axi_wvalid & s_axi_wready;
   assign wr_go   = (aw_held_reg | aw_fire) & (w_held_reg | w_fire);
   assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
   assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata[7:0];
   assign wr_lane = w_held_reg ? wstrb_reg : s_axi_wstrb[0];

   always_comb begin
      aw_held_next = aw_held_reg;
      awaddr_next  = awaddr_reg;
      w_held_next  = w_held_reg;
      wdata_next   = wdata_reg;
      wstrb_next   = wstrb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      if (bvalid_reg && s_axi_bready) begin
         bvalid_next = 1'b0;
      end
      if (aw_fire) begin
         aw_held_next = 1'b1;
         awaddr_next  = s_axi_awaddr;
      end
      if (w_fire) begin
         w_held_next = 1'b1;
         wdata_next  = s_axi_wdata[7:0];
         wstrb_next  = s_axi_wstrb[0];
      end
      if (wr_go) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
         case (wr_addr)
            `ADDR_MOD_CTRL: bresp_next = RESP_OKAY;
            `ADDR_MOD_SRC:  bresp_next = RESP_OKAY;
            default:        bresp_next = RESP_SLVERR;
         endcase
      end
      // readies are copies of next state, so taking costs no extra cycle
      awready_next = ~aw_held_next & ~bvalid_next;
      wready_next  = ~w_held_next & ~bvalid_next;
   end

   // control and source registers; a write with lane 0 off is answered
   // but changes nothing
   always_comb begin
      ctrl_next = ctrl_reg;
      src_next  = src_reg;
      if (wr_go && wr_lane) begin
         case (wr_addr)
            `ADDR_MOD_CTRL: begin
               ctrl_next = wr_data & `CTRL_WR_MASK;
            end
            `ADDR_MOD_SRC: begin
               src_next = wr_data & `SRC_WR_MASK;
            end
            default: begin
               ctrl_next = ctrl_reg;
            end
         endcase
      end
   end

   // read channel: one outstanding read, answer one cycle after address
   always_comb begin
      rvalid_next = rvalid_reg;
      rresp_next  = rresp_reg;
      rdata_next  = rdata_reg;
      if (rvalid_reg && s_axi_rready) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_next = 1'b1;
         rresp_next  = RESP_OKAY;
         rdata_next  = 32'h0000_0000;
         case (s_axi_araddr)
            `ADDR_MOD_CTRL: begin
               rdata_next[7:0] = ctrl_reg;
               rdata_next[`CTRL_STATUS_BIT] = status_reg;
            end
            `ADDR_MOD_SRC: rdata_next[7:0] = src_reg;
            default:       rresp_next = RESP_SLVERR;
         endcase
      end
      arready_next = ~rvalid_next;
   end

   // pin stage is registered so every output leaves from a flip-flop;
   // costs one clock of latency on the pin versus the raw mix
   always_comb begin
      status_next = mixed ^ ctrl_reg[`CTRL_INV_BIT];
      oe_next     = ctrl_reg[`CTRL_OE_BIT];
      pin_next    = ctrl_reg[`CTRL_OE_BIT] & status_next;
      slew_next   = ctrl_reg[`CTRL_SLEW_BIT];
   end

   // the select field names one source, so at most one pin is cut loose
   generate
      for (ch = 0; ch < 4; ch = ch + 1) begin : g_disc
         assign disc_next[ch] = src_reg[`SRC_DISC_BIT] &
                                (sel == disc_code[ch]);
      end
   endgenerate

   // settings survive a module-off; only reset restores the defaults
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `CTRL_RESET;
         src_reg  <= `SRC_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
         src_reg  <= src_next;
      end
   end

   // write channel state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         awaddr_reg  <= 4'h0;
         w_held_reg  <= 1'b0;
         wdata_reg   <= 8'h00;
         wstrb_reg   <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= 2'h0;
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
      end else begin
         aw_held_reg <= aw_held_next;
         awaddr_reg  <= awaddr_next;
         w_held_reg  <= w_held_next;
         wdata_reg   <= wdata_next;
         wstrb_reg   <= wstrb_next;
         bvalid_reg  <= bvalid_next;
         bresp_reg   <= bresp_next;
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
      end
   end

   // read channel state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg  <= 1'b0;
         rresp_reg   <= 2'h0;
         rdata_reg   <= 32'h0000_0000;
         arready_reg <= 1'b1;
      end else begin
         rvalid_reg  <= rvalid_next;
         rresp_reg   <= rresp_next;
         rdata_reg   <= rdata_next;
         arready_reg <= arready_next;
      end
   end

   // pin stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= 1'b0;
         pin_reg    <= 1'b0;
         oe_reg     <= 1'b0;
         slew_reg   <= 1'b1;
         disc_reg   <= 4'h0;
      end else begin
         status_reg <= status_next;
         pin_reg    <= pin_next;
         oe_reg     <= oe_next;
         slew_reg   <= slew_next;
         disc_reg   <= disc_next;
      end
   end

   assign s_axi_awready             = awready_reg;
   assign s_axi_wready              = wready_reg;
   assign s_axi_arready             = arready_reg;
   assign s_axi_bvalid              = bvalid_reg;
   assign s_axi_bresp               = bresp_reg;
   assign s_axi_rvalid              = rvalid_reg;
   assign s_axi_rresp               = rresp_reg;
   assign s_axi_rdata               = rdata_reg;
   assign mod_pin_out               = pin_reg;
   assign mod_pin_oe                = oe_reg;
   assign pin_slew_limit            = slew_reg;
   assign pwm_pin_disconnect        = disc_reg[0];
   assign comparator_pin_disconnect = disc_reg[1];
   assign sync_sdo_pin_disconnect   = disc_reg[2];
   assign serial_tx_pin_disconnect  = disc_reg[3];
endmodule

/* hw/signal_modulator_map.svh */
`ifndef SIGNAL_MODULATOR_MAP_SVH
`define SIGNAL_MODULATOR_MAP_SVH

`define ADDR_MOD_CTRL      4'h0
`define ADDR_MOD_SRC       4'h4

`define CTRL_ON_BIT        7
`define CTRL_OE_BIT        6
`define CTRL_SLEW_BIT      5
`define CTRL_INV_BIT       4
`define CTRL_STATUS_BIT    3
`define CTRL_SOFT_BIT      0
`define CTRL_WR_MASK       8'hF1
`define CTRL_RESET         8'h20

`define SRC_DISC_BIT       7
`define SRC_SEL_MSB        3
`define SRC_WR_MASK        8'h8F
`define SRC_RESET          8'h00

`define SEL_SOFT           4'h0
`define SEL_EXT_PIN        4'h1
`define SEL_PWM            4'h2
`define SEL_COMPARATOR     4'h7
`define SEL_SYNC_SDO       4'h8
`define SEL_SERIAL_TX      4'hA

`endif

/* hw/signal_modulator_pkg.sv */
package signal_modulator_pkg;
   typedef logic [3:0] src_sel_t;
   typedef enum logic [1:0] {
      RESP_OKAY   = 2'h0,
      RESP_SLVERR = 2'h2
   } axi_resp_e;
endpackage

/* hw/mod_mixer.sv */
`timescale 1ns/1ns
`include "signal_modulator_map.svh"
module mod_mixer
   import signal_modulator_pkg::*;
(
   input  wire logic     module_on,
   input  wire logic     soft_mod_value,
   input  wire src_sel_t mod_src_select,
   input  wire logic     ext_mod_input_pin,
   input  wire logic     pwm_src,
   input  wire logic     comparator_src,
   input  wire logic     sync_sdo_src,
   input  wire logic     serial_tx_src,
   input  wire logic     carrier_high,
   input  wire logic     carrier_low,
   output logic          mixed
);
   logic mod_sig;
   logic car_h;
   logic car_l;

   // purely combinational, but its result reaches mod_pin_out only through the aclk pin stage, which stops with the bus clock
   always_comb begin
      mod_sig = 1'b0;
      if (!module_on) begin
         mod_sig = soft_mod_value;
      end else begin
         case (mod_src_select)
            `SEL_SOFT:       mod_sig = soft_mod_value;
            `SEL_EXT_PIN:    mod_sig = ext_mod_input_pin;
            `SEL_PWM:        mod_sig = pwm_src;
            `SEL_COMPARATOR: mod_sig = comparator_src;
            `SEL_SYNC_SDO:   mod_sig = sync_sdo_src;
            `SEL_SERIAL_TX:  mod_sig = serial_tx_src;
            default:         mod_sig = 1'b0;
         endcase
      end
      car_h = module_on & carrier_high;
      car_l = module_on & carrier_low;
      mixed = (mod_sig & car_h) | (~mod_sig & car_l);
   end
endmodule

/* sim/signal_modulator_properties.sv */
`timescale 1ns/1ns
module signal_modulator_checker (
   input logic        aclk,
   input logic        aresetn,
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic        s_axi_rvalid,
   input logic [31:0] s_axi_rdata,
   input logic        mod_pin_out,
   input logic        mod_pin_oe,
   input logic        pin_slew_limit,
   input logic        pwm_pin_disconnect,
   input logic        comparator_pin_disconnect,
   input logic        sync_sdo_pin_disconnect,
   input logic        serial_tx_pin_disconnect
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_answer;
      s_axi_bvalid && !s_axi_awready && !s_axi_wready;
   endsequence
   property p_wr_answer; s_wr_taken |=> s_wr_answer; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("no write answer");
   property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
   property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("no read data");
   property p_r_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r_refuse: assert property (p_r_refuse) else $error("read overlap");
   property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_r_upper: assert property (p_r_upper) else $error("upper bits set");
   property p_drive_off; !mod_pin_oe |-> !mod_pin_out; endproperty
   a_drive_off: assert property (p_drive_off) else $error("pin not low");
   property p_reset;
      $past(!aresetn) |-> pin_slew_limit && !mod_pin_oe && !mod_pin_out;
   endproperty
   a_reset: assert property (p_reset) else $error("bad reset pins");
   property p_disc_one;
      $onehot0({pwm_pin_disconnect, comparator_pin_disconnect,
                sync_sdo_pin_disconnect, serial_tx_pin_disconnect});
   endproperty
   a_disc_one: assert property (p_disc_one) else $error("two disconnects");
endmodule
bind signal_modulator signal_modulator_checker chk (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rdata, .mod_pin_out, .mod_pin_oe, .pin_slew_limit,
   .pwm_pin_disconnect, .comparator_pin_disconnect,
   .sync_sdo_pin_disconnect, .serial_tx_pin_disconnect);

/* sim/source_model.sv */
`timescale 1ns/1ns
module source_model (
   input  logic       aclk,
   input  logic       run,
   output logic [6:0] levels
);
   // frozen between bursts so register reads see a settled status bit
   initial levels = 7'h00;
   always @(posedge aclk) begin
      if (run) begin
         levels <= 7'($urandom);
      end
   end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import signal_modulator_pkg::*;
   logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0, chk_en = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, mod_pin_out, mod_pin_oe, pin_slew_limit;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [3:0] disc;
   logic [6:0] lv;
   logic [7:0] cc = 8'h20, sc = 8'h00, ex;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   always #5 aclk = ~aclk;
   signal_modulator uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .ext_mod_input_pin(lv[6]), .pwm_src(lv[5]), .comparator_src(lv[4]),
      .sync_sdo_src(lv[3]), .serial_tx_src(lv[2]), .carrier_high(lv[1]),
      .carrier_low(lv[0]), .mod_pin_out, .mod_pin_oe, .pin_slew_limit,
      .pwm_pin_disconnect(disc[3]), .comparator_pin_disconnect(disc[2]),
      .sync_sdo_pin_disconnect(disc[1]), .serial_tx_pin_disconnect(disc[0]));
   source_model sm (.aclk, .run, .levels(lv));
   function automatic logic [7:0] model(logic [7:0] c, s, logic [6:0] v);
      logic m;
      logic mix;
      m = c[0];
      if (c[7]) begin
         case (s[3:0])
            4'h0: m = c[0];
            4'h1: m = v[6];
            4'h2: m = v[5];
            4'h7: m = v[4];
            4'h8: m = v[3];
            4'hA: m = v[2];
            default: m = 1'h0;
         endcase
      end
      mix = c[7] & (m ? v[1] : v[0]);
      return {mix ^ c[4], c[6] & (mix ^ c[4]), c[6], c[5], {4{s[7]}} &
              {s[3:0] == 4'h2, s[3:0] == 4'h7, s[3:0] == 4'h8, s[3:0] == 4'hA}};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v,
                     input logic [3:0] s, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] v,
                     output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      v = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   task automatic chk_regs;
      rd(4'h0, d, r);
      chk(d, {24'h0, cc & 8'hF1 | {4'h0, ex[7], 3'h0}});
      rd(4'h4, d, r);
      chk(d, {24'h0, sc & 8'h8F});
   endtask
   always @(posedge aclk) ex <= model(cc, sc, lv);
   always @(negedge aclk) begin
      if (chk_en) begin
         chk({25'h0, mod_pin_out, mod_pin_oe, pin_slew_limit, disc},
             {25'h0, ex[6:0]});
      end
   end
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         $display("[ERR] %0t timeout", $time);
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      void'($urandom(32'h86E4));
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      chk_regs();
      wr(4'h8, $urandom, 4'hF, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(4'h8, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      chk(d, 32'h0);
      wr(4'h0, 32'hFF, 4'h0, r);
      chk_regs();
      for (int i = 0; i < 32; i++) begin
         sc = 8'($urandom) & 8'hF0 | 8'(i[3:0]);
         cc = 8'($urandom);
         cc[7] = ~i[4];
         // sources set up before the control word enables the pin
         wr(4'h4, {24'($urandom), sc}, 4'h1, r);
         wr(4'h0, {24'($urandom), cc}, 4'($urandom) | 4'h1, r);
         repeat (2) @(posedge aclk);
         chk_regs();
         chk_en <= 1'h1;
         run <= 1'h1;
         repeat (20) @(posedge aclk);
         run <= 1'h0;
         chk_en <= 1'h0;
      end
      aresetn <= 1'h0;
      cc = 8'h20;
      sc = 8'h00;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      chk_regs();
      give_verdict();
   end
endmodule
